// File: design/sbc_commutator.v
// Sensorless BLDC commutator with AHB-Lite register slave
// Summary of operation
// RQ1: Speed code at or above stop code: align first, then forced stepping
// RQ2: Leave alignment when timing node reaches half
// RQ3: Go sensorless when rotation beats forced rate
// RQ4: Sensed polarity edges then set commutation timing
// RQ5: Duty always from ramped speed voltage
// RQ6: Rate select picks forced step period
// RQ7: PWM carrier is clock divided by 256
// RQ8: Six-bit speed code sets PWM duty
// RQ9: Code below 1 V stops, ramp cleared
// RQ10: Fault disables outputs, retries after one second; duty_monitor still follows the PWM in fault
// RQ11: Too fast or too slow is fault
// RQ12: Sample position on PWM falling edge
// RQ13: Detection on each change of sensed level, rising or falling
// RQ14: Forced uses zero lead, sensorless selected lead
// RQ15: Overlap select high 120 degree, low overlap
// RQ16: Overlap length scales with lead angle
// RQ17: Lead select low 7.5, high 15 degrees
// RQ18: Overcurrent stops all six drives
// RQ19: Low sides active high, high sides selectable
// RQ20: Eight-bit counter compared with duty code
// RQ21: Six steps, one high one low each
// RQ22: Retry or stop restarts from alignment
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sbc_consts.vh"
module sbc_commutator #(
	parameter RETRY_CYCLES = `SBC_RETRY_TIME_MS * `SBC_HCLK_KHZ,
	parameter FORCED_STEP_CYCLES = `SBC_FORCED_STEP_CYCLES
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire align_timing_node_low,
	input wire position_sense,
	input wire overcurrent_input,
	output reg phase_u_high_drive,
	output reg phase_v_high_drive,
	output reg phase_w_high_drive,
	output reg phase_u_low_drive,
	output reg phase_v_low_drive,
	output reg phase_w_low_drive,
	output reg duty_monitor
);
	localparam ST_IDLE = 5'b00001;
	localparam ST_ALIGN = 5'b00010;
	localparam ST_FORCED = 5'b00100;
	localparam ST_SENSE = 5'b01000;
	localparam ST_FAULT = 5'b10000;
	localparam [19:0] STEP_HI = FORCED_STEP_CYCLES[19:0];
	localparam [24:0] RETRY_N = RETRY_CYCLES[24:0];
	// Six-step table: high side in [5:3], low side in [2:0]
	function [5:0] step_map;
		input [2:0] s;
		begin
			case (s)
				3'd0: step_map = 6'b100_010;
				3'd1: step_map = 6'b100_001;
				3'd2: step_map = 6'b010_001;
				3'd3: step_map = 6'b010_100;
				3'd4: step_map = 6'b001_100;
				3'd5: step_map = 6'b001_010;
				default: step_map = 6'b000_000;
			endcase
		end
	endfunction
	function [2:0] step_inc;
		input [2:0] s;
		begin
			step_inc = (s == 3'd5) ? 3'd0 : s + 3'd1;
		end
	endfunction
	// Bus slave
	reg [5:0] speed_r;
	reg [4:0] cfg_r;
	reg wr_pend_r;
	reg [3:0] wr_addr_r;
	wire addr_ok;
	assign addr_ok = hsel & htrans[1] & hready;
	// Core state
	reg [4:0] state_r;
	reg [4:0] state_nxt;
	reg [2:0] step_r;
	reg [2:0] prev_step_r;
	reg [5:0] ramp_r;
	reg [15:0] ramp_cnt_r;
	reg [19:0] step_cnt_r;
	reg [19:0] intv_r;
	reg [19:0] period_r;
	reg [19:0] delay_r;
	reg delay_run_r;
	reg [19:0] ovl_r;
	reg [24:0] retry_r;
	reg sense_s_r;
	reg sense_edge_r;
	wire pwm;
	wire pwm_fall;
	wire stop_req;
	wire lead15;
	wire [19:0] forced_len;
	wire [19:0] lag;
	wire [19:0] ovl_len;
	wire fast_fault;
	wire slow_fault;
	wire commutate;

	assign stop_req = speed_r < `SBC_STOP_CODE; // RQ9
	assign lead15 = cfg_r[`SBC_CFG_LEAD_BIT]; // RQ17
	assign forced_len = (cfg_r[1:0] == `SBC_RATE_LOW) ? {STEP_HI[17:0], 2'b00} :
		(cfg_r[1:0] == `SBC_RATE_MID) ? {STEP_HI[18:0], 1'b0} : STEP_HI; // RQ6
	// Delay from zero crossing to commutation: 30 degrees minus lead
	assign lag = lead15 ? {2'b00, period_r[19:2]} :
		({2'b00, period_r[19:2]} + {3'b000, period_r[19:3]}); // RQ14
	assign ovl_len = lead15 ? {2'b00, period_r[19:2]} : {3'b000, period_r[19:3]}; // RQ16
	assign fast_fault = sense_edge_r & (intv_r < `SBC_MIN_STEP_CYCLES); // RQ11
	assign slow_fault = intv_r >= forced_len; // RQ11
	assign commutate = (state_r == ST_SENSE) ? (delay_run_r && delay_r == 20'h00000) :
		(state_r == ST_FORCED) ? (step_cnt_r >= forced_len - 20'h00001) : 1'b0;

	sbc_pwm_gen u_pwm (
		.hclk(hclk),
		.hresetn(hresetn),
		.duty_code(ramp_r), // RQ5 RQ8
		.pwm_r(pwm),
		.pwm_fall_r(pwm_fall)
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 4'h0;
			speed_r <= `SBC_SPEED_RST;
			cfg_r <= `SBC_CFG_RST;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= addr_ok & hwrite & (haddr[7:4] == 4'h0);
			if (addr_ok) begin
				wr_addr_r <= haddr[3:0];
			end
			if (wr_pend_r && wr_addr_r == `SBC_ADDR_SPEED) begin
				speed_r <= hwdata[5:0];
			end
			if (wr_pend_r && wr_addr_r == `SBC_ADDR_CFG) begin
				cfg_r <= hwdata[4:0];
			end
			if (addr_ok && !hwrite) begin
				case (haddr[7:0])
					{4'h0, `SBC_ADDR_SPEED}: hrdata <= {26'h0000000, speed_r};
					{4'h0, `SBC_ADDR_CFG}: hrdata <= {27'h0000000, cfg_r};
					{4'h0, `SBC_ADDR_STATUS}: hrdata <= {10'h000, ramp_r, 5'h00, step_r,
						overcurrent_input, 2'b00, state_r};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (!stop_req) begin
					state_nxt = ST_ALIGN; // RQ1
				end
			end
			ST_ALIGN: begin
				if (align_timing_node_low) begin
					state_nxt = ST_FORCED; // RQ2
				end
			end
			ST_FORCED: begin
				if (sense_edge_r && intv_r < forced_len) begin
					state_nxt = ST_SENSE; // RQ3 RQ4
				end
			end
			ST_SENSE: begin
				if (fast_fault || slow_fault) begin
					state_nxt = ST_FAULT; // RQ10
				end
			end
			ST_FAULT: begin
				if (retry_r >= RETRY_N - 25'h0000001) begin
					state_nxt = ST_IDLE; // RQ22
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (stop_req) begin
			state_nxt = ST_IDLE; // RQ22
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			step_r <= 3'd0;
			prev_step_r <= 3'd0;
			ramp_r <= 6'h00;
			ramp_cnt_r <= 16'h0000;
			step_cnt_r <= 20'h00000;
			intv_r <= 20'h00000;
			period_r <= 20'h00000;
			delay_r <= 20'h00000;
			delay_run_r <= 1'b0;
			ovl_r <= 20'h00000;
			retry_r <= 25'h0000000;
			sense_s_r <= 1'b0;
			sense_edge_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// Ramped speed voltage follows the command
			if (stop_req) begin
				ramp_r <= 6'h00; // RQ9
				ramp_cnt_r <= 16'h0000;
			end else if (ramp_r == speed_r) begin
				ramp_cnt_r <= 16'h0000;
			end else if (ramp_r < speed_r) begin
				if (ramp_cnt_r >= `SBC_RAMP_UP_CYCLES - 16'h0001) begin
					ramp_cnt_r <= 16'h0000;
					ramp_r <= ramp_r + 6'h01;
				end else begin
					ramp_cnt_r <= ramp_cnt_r + 16'h0001;
				end
			end else begin
				if (ramp_cnt_r >= `SBC_RAMP_DOWN_CYCLES - 16'h0001) begin
					ramp_cnt_r <= 16'h0000;
					ramp_r <= ramp_r - 6'h01;
				end else begin
					ramp_cnt_r <= ramp_cnt_r + 16'h0001;
				end
			end
			// Position sampled on PWM falling edge
			sense_edge_r <= 1'b0;
			if (pwm_fall) begin
				sense_s_r <= position_sense; // RQ12 RQ13
				sense_edge_r <= position_sense ^ sense_s_r; // RQ13
			end
			// Interval between sensed edges, saturating
			if (sense_edge_r || state_r == ST_IDLE || state_r == ST_ALIGN) begin
				intv_r <= 20'h00001;
			end else if (intv_r != 20'hFFFFF) begin
				intv_r <= intv_r + 20'h00001;
			end
			if (sense_edge_r) begin
				period_r <= intv_r;
			end
			// Forced step timer
			if (state_r == ST_FORCED && !commutate) begin
				step_cnt_r <= step_cnt_r + 20'h00001;
			end else begin
				step_cnt_r <= 20'h00000;
			end
			// Lead-adjusted delay after each sensed edge
			if (state_r != ST_SENSE) begin
				delay_run_r <= 1'b0;
			end else if (sense_edge_r) begin
				delay_run_r <= 1'b1; // RQ4
				delay_r <= lead15 ? {2'b00, intv_r[19:2]} :
					({2'b00, intv_r[19:2]} + {3'b000, intv_r[19:3]}); // RQ14
			end else if (delay_run_r) begin
				if (delay_r == 20'h00000) begin
					delay_run_r <= 1'b0;
				end else begin
					delay_r <= delay_r - 20'h00001;
				end
			end
			// Step sequencing
			if (state_r == ST_IDLE || state_r == ST_ALIGN) begin
				step_r <= 3'd0;
				prev_step_r <= 3'd0;
				ovl_r <= 20'h00000;
			end else if (commutate) begin
				prev_step_r <= step_r;
				step_r <= step_inc(step_r); // RQ21
				ovl_r <= (state_r == ST_SENSE) ? ovl_len : 20'h00000; // RQ16
			end else if (ovl_r != 20'h00000) begin
				ovl_r <= ovl_r - 20'h00001;
			end
			// Retry wait
			if (state_r == ST_FAULT) begin
				retry_r <= retry_r + 25'h0000001; // RQ10
			end else begin
				retry_r <= 25'h0000000;
			end
		end
	end

	// Output drive: overlap, chopping, gating and polarity
	reg [5:0] drv;
	reg [5:0] drv_nxt;
	reg [2:0] hi;
	always @* begin
		drv = step_map(step_r); // RQ21
		if (!cfg_r[`SBC_CFG_OVL_BIT] && ovl_r != 20'h00000 && lag != 20'h00000) begin
			drv = drv | step_map(prev_step_r); // RQ15
		end
		hi = drv[5:3] & {3{pwm}}; // RQ21
		drv_nxt = {hi, drv[2:0]};
		if (state_r == ST_IDLE || state_r == ST_FAULT || overcurrent_input) begin
			drv_nxt = 6'b000_000; // RQ10 RQ18
		end
		if (cfg_r[`SBC_CFG_POL_BIT]) begin
			drv_nxt[5:3] = ~drv_nxt[5:3]; // RQ19
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_u_high_drive <= 1'b0;
			phase_v_high_drive <= 1'b0;
			phase_w_high_drive <= 1'b0;
			phase_u_low_drive <= 1'b0;
			phase_v_low_drive <= 1'b0;
			phase_w_low_drive <= 1'b0;
			duty_monitor <= 1'b0;
		end else begin
			phase_u_high_drive <= drv_nxt[5];
			phase_v_high_drive <= drv_nxt[4];
			phase_w_high_drive <= drv_nxt[3];
			phase_u_low_drive <= drv_nxt[2]; // RQ19
			phase_v_low_drive <= drv_nxt[1];
			phase_w_low_drive <= drv_nxt[0];
			duty_monitor <= pwm & ~overcurrent_input;
		end
	end
endmodule
`default_nettype wire

// File: design/sbc_consts.vh
// Constants for the sensorless commutator: map, fields, resets, timing
`ifndef SBC_CONSTS_VH
`define SBC_CONSTS_VH
`define SBC_ADDR_SPEED 4'h0
`define SBC_ADDR_CFG 4'h4
`define SBC_ADDR_STATUS 4'h8
`define SBC_SPEED_RST 6'h00
`define SBC_CFG_RST 5'h0B
`define SBC_CFG_RATE_LSB 0
`define SBC_CFG_LEAD_BIT 2
`define SBC_CFG_OVL_BIT 3
`define SBC_CFG_POL_BIT 4
`define SBC_RATE_LOW 2'h0
`define SBC_RATE_MID 2'h1
`define SBC_STOP_CODE 6'h0D
`define SBC_PWM_BITS 8
`define SBC_HCLK_KHZ 20000
`define SBC_RETRY_TIME_MS 1000
`define SBC_FORCED_STEP_CYCLES 65536
`define SBC_MIN_STEP_CYCLES 20'h00400
`define SBC_RAMP_UP_CYCLES 16'h0400
`define SBC_RAMP_DOWN_CYCLES 16'h0080
`endif

// File: design/sbc_pwm_gen.v
// PWM carrier: free-running counter, duty compare, falling-edge strobe
`timescale 1ns/10ps
`default_nettype none
`include "sbc_consts.vh"
module sbc_pwm_gen (
	input wire hclk,
	input wire hresetn,
	input wire [5:0] duty_code,
	output reg pwm_r,
	output reg pwm_fall_r
);
	reg [`SBC_PWM_BITS-1:0] cnt_r;
	wire [`SBC_PWM_BITS-1:0] duty8;
	assign duty8 = {duty_code, 2'b00};
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 8'h00;
			pwm_r <= 1'b0;
			pwm_fall_r <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 8'h01; // RQ7
			pwm_r <= (cnt_r < duty8); // RQ20
			pwm_fall_r <= pwm_r & ~(cnt_r < duty8); // RQ12
		end
	end
endmodule
`default_nettype wire

// File: testbench/sbc_bridge_model.sv
// Bridge and rotor stand-in: alignment node and back-EMF polarity
`timescale 1ns/10ps
`default_nettype none
module sbc_bridge_model #(
	parameter int ALIGN_DLY = 200,
	parameter int PERIOD = 1536
) (
	input wire logic hclk,
	input wire logic any_low,
	input wire logic spin_en,
	output logic align_timing_node_low,
	output logic position_sense
);
	int acnt_r = 0;
	int pcnt_r = 0;
	logic atn_r = 1'b0;
	logic pol_r = 1'b0;
	assign align_timing_node_low = atn_r;
	assign position_sense = pol_r;
	always @(posedge hclk) begin
		acnt_r <= any_low ? acnt_r + 1 : 0;
		atn_r <= any_low && acnt_r >= ALIGN_DLY;
		pcnt_r <= (spin_en && pcnt_r < PERIOD - 1) ? pcnt_r + 1 : 0;
		if (spin_en && pcnt_r == PERIOD - 1) begin
			pol_r <= ~pol_r;
		end
	end
endmodule
`default_nettype wire

// File: testbench/sbc_commutator_props.sv
// Checker of drive and bus relations
`timescale 1ns/10ps
`default_nettype none
module sbc_commutator_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic overcurrent_input,
	input wire logic phase_u_high_drive,
	input wire logic phase_v_high_drive,
	input wire logic phase_w_high_drive,
	input wire logic phase_u_low_drive,
	input wire logic phase_v_low_drive,
	input wire logic phase_w_low_drive,
	input wire logic duty_monitor
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [8:0] hi_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_r <= 9'h000;
		end else begin
			hi_r <= duty_monitor ? hi_r + 9'h001 : 9'h000;
		end
	end
	property p_ovc_low;
		overcurrent_input |=> !(phase_u_low_drive || phase_v_low_drive || phase_w_low_drive);
	endproperty
	a_ovc_low: assert property (p_ovc_low) else $error("low drive on in overcurrent");
	property p_ovc_duty;
		overcurrent_input |=> !duty_monitor;
	endproperty
	a_ovc_duty: assert property (p_ovc_duty) else $error("pwm on in overcurrent");
	property p_ovc_high;
		overcurrent_input |=> (phase_u_high_drive == phase_v_high_drive)
			&& (phase_v_high_drive == phase_w_high_drive);
	endproperty
	a_ovc_high: assert property (p_ovc_high) else $error("high drive on in overcurrent");
	property p_duty_max;
		hi_r <= 9'h0FC;
	endproperty
	a_duty_max: assert property (p_duty_max) else $error("pwm high too long");
	property p_low_max;
		!(phase_u_low_drive && phase_v_low_drive && phase_w_low_drive);
	endproperty
	a_low_max: assert property (p_low_max) else $error("three low drives on");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("bad bus response");
	property p_ready;
		hreadyout;
	endproperty
	a_ready: assert property (p_ready) else $error("wait state inserted");
	property p_rd_hold;
		!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	c_ovc: cover property (overcurrent_input ##1 overcurrent_input);
	c_ovl: cover property (phase_v_low_drive && phase_w_low_drive);
	c_step: cover property ($rose(phase_w_low_drive));
endmodule
bind sbc_commutator sbc_commutator_props u_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .overcurrent_input(overcurrent_input),
	.phase_u_high_drive(phase_u_high_drive), .phase_v_high_drive(phase_v_high_drive),
	.phase_w_high_drive(phase_w_high_drive), .phase_u_low_drive(phase_u_low_drive),
	.phase_v_low_drive(phase_v_low_drive), .phase_w_low_drive(phase_w_low_drive),
	.duty_monitor(duty_monitor));
`default_nettype wire

// File: testbench/tb_top.sv
// Testbench for the sensorless commutator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int LSTEP = 2048;
	localparam int PSENS = 1536;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic ovc = 1'b0;
	logic spin = 1'b0;
	logic msel = 1'b0;
	logic [31:0] rd;
	int n_mismatch = 0;
	int total_checks = 0;
	wire [31:0] hrdata;
	wire hrdy, atn, psn, u_hi, v_hi, w_hi, u_lo, v_lo, w_lo, duty;
	wire mon = msel ? duty : w_lo;
	wire two_lo = (u_lo & v_lo) | (v_lo & w_lo) | (u_lo & w_lo);
	always #25 hclk = ~hclk;
	sbc_commutator #(.RETRY_CYCLES(2000), .FORCED_STEP_CYCLES(LSTEP)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
		.hresp(), .align_timing_node_low(atn), .position_sense(psn),
		.overcurrent_input(ovc), .phase_u_high_drive(u_hi), .phase_v_high_drive(v_hi),
		.phase_w_high_drive(w_hi), .phase_u_low_drive(u_lo), .phase_v_low_drive(v_lo),
		.phase_w_low_drive(w_lo), .duty_monitor(duty));
	sbc_bridge_model #(.ALIGN_DLY(200), .PERIOD(PSENS)) u_bridge (.hclk(hclk),
		.any_low(u_lo | v_lo | w_lo), .spin_en(spin), .align_timing_node_low(atn),
		.position_sense(psn));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int k;
		k = 0;
		do begin
			bus(32'h8, 1'b0, 32'h0);
			k++;
		end while ((rd & m) !== v && k < 20000);
	endtask
	task automatic meas(input logic s, output int hi, output int per);
		msel = s;
		hi = 1;
		per = 0;
		do @(negedge hclk); while (mon !== 1'b0);
		do @(negedge hclk); while (mon !== 1'b1);
		do begin
			@(negedge hclk);
			per++;
			if (mon === 1'b1 && per == hi) hi++;
		end while (!(mon === 1'b1 && per > hi));
	endtask
	task automatic olap(output int n);
		int k;
		k = 0;
		n = 0;
		do begin
			@(negedge hclk);
			k++;
		end while (two_lo === 1'b1 && k < 8 * PSENS);
		do begin
			@(negedge hclk);
			k++;
		end while (two_lo !== 1'b1 && k < 8 * PSENS);
		while (two_lo === 1'b1 && k < 8 * PSENS) begin
			@(negedge hclk);
			n++;
			k++;
		end
	endtask
	task automatic t_regs;
		bus(32'h4, 1'b0, 32'h0);
		chk(rd, 32'h0000000B);
		bus(32'h0, 1'b0, 32'h0);
		chk(rd, 32'h0);
		bus(32'hC, 1'b0, 32'h0);
		chk(rd, 32'h0);
		bus(32'h8, 1'b0, 32'h0);
		chk(rd & 32'h1F, 32'h1);
		$display("regs done");
	endtask
	task automatic t_start;
		int hi, per;
		bus(32'h0, 1'b1, 32'h20);
		poll(32'h1F, 32'h2);
		chk(rd & 32'h1F, 32'h2);
		chk({31'h0, v_lo}, 32'h1);
		poll(32'h1F, 32'h4);
		chk(rd & 32'h1F, 32'h4);
		meas(1'b0, hi, per);
		chk(hi, 2 * LSTEP);
		chk(per, 6 * LSTEP);
		poll(32'h3F0000, 32'h200000);
		chk(rd & 32'h3F0000, 32'h200000);
		meas(1'b1, hi, per);
		chk(hi, 128);
		chk(per, 256);
		$display("start done");
	endtask
	task automatic t_sens;
		int hi, per, k;
		@(posedge hclk);
		spin <= 1'b1;
		poll(32'h1F, 32'h8);
		chk(rd & 32'h1F, 32'h8);
		repeat (2 * PSENS) @(posedge hclk);
		meas(1'b0, hi, per);
		chk(hi, 2 * PSENS);
		chk(per, 6 * PSENS);
		bus(32'h4, 1'b1, 32'h3);
		k = 0;
		do begin
			@(negedge hclk);
			k++;
		end while (!(v_lo === 1'b1 && w_lo === 1'b1) && k < 8 * PSENS);
		chk({31'h0, v_lo & w_lo}, 32'h1);
		olap(k);
		chk(k, PSENS / 8);
		bus(32'h4, 1'b1, 32'h7);
		olap(k);
		chk(k, PSENS / 4);
		$display("sensorless done");
	endtask
	task automatic t_fault;
		bus(32'h4, 1'b1, 32'h17);
		@(posedge hclk);
		ovc <= 1'b1;
		bus(32'h8, 1'b0, 32'h0);
		chk(rd & 32'h80, 32'h80);
		chk({28'h0, u_lo, v_lo, w_lo, duty}, 32'h0);
		chk({29'h0, u_hi, v_hi, w_hi}, 32'h7);
		ovc <= 1'b0;
		spin <= 1'b0;
		poll(32'h1F, 32'h10);
		chk(rd & 32'h1F, 32'h10);
		chk({26'h0, u_hi, v_hi, w_hi, u_lo, v_lo, w_lo}, 32'h38);
		poll(32'h1F, 32'h2);
		chk(rd & 32'h1F, 32'h2);
		bus(32'h0, 1'b1, 32'hC);
		poll(32'h1F, 32'h1);
		chk(rd & 32'h3F001F, 32'h1);
		bus(32'h0, 1'b1, 32'hD);
		poll(32'h1F, 32'h2);
		chk(rd & 32'h1F, 32'h2);
		$display("fault and stop done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_start;
		t_sens;
		t_fault;
		close_out;
	end
	initial begin
		#4900000;
		n_mismatch++;
		close_out;
	end
endmodule
`default_nettype wire
